// >>> hdl/i2cu_params.svh
// constants of the i2c update port: addresses, bit positions, timing counts
// included by the design and bench files; holds definitions only
`ifndef I2CU_PARAMS_SVH
`define I2CU_PARAMS_SVH

// address byte fields
`define I2CU_ADDR_HI       4'h9
`define I2CU_BCAST_ADDR    7'h47
`define I2CU_GCALL_BYTE    8'h00
`define I2CU_GCALL_RESET   8'h06
`define I2CU_RW_WRITE      1'b0
`define I2CU_RW_READ       1'b1

// strap decode codes, low three address bits
`define I2CU_STRAP_GND     3'h0
`define I2CU_STRAP_VDD     3'h1
`define I2CU_STRAP_SDA     3'h2
`define I2CU_STRAP_SCL     3'h3

// bit and byte positions within a frame
`define I2CU_LAST_DATA_BIT 4'h7
`define I2CU_ACK_BIT       4'h8
`define I2CU_IDX_ADDR      2'h0
`define I2CU_IDX_CMD       2'h1
`define I2CU_IDX_UPPER     2'h2
`define I2CU_IDX_LOWER     2'h3

// host step numbers
`define I2CU_STEP_CMD      3'h1
`define I2CU_STEP_RD_UP    3'h3
`define I2CU_STEP_RD_LO    3'h4

// timing: mclk period and host scl period, count of mclk cycles per quarter bit
`define I2CU_MCLK_NS       5
`define I2CU_SCL_PERIOD_NS 2500
`define I2CU_QUARTER_CYC   ((`I2CU_SCL_PERIOD_NS / 4) / `I2CU_MCLK_NS)

`endif

// >>> hdl/i2cu_pkg.sv
// types of the i2c update port, used by the controller end and the bench
// no dependencies
package i2cu_pkg;

   typedef enum logic [1:0] {
      I2CU_OP_WRITE,
      I2CU_OP_SHORT,
      I2CU_OP_READ
   } i2cu_op_t;

   typedef enum logic [1:0] {
      I2CU_H_IDLE,
      I2CU_H_START,
      I2CU_H_BIT,
      I2CU_H_STOP
   } i2cu_hstate_t;

endpackage

// >>> hdl/i2cu_if.sv
// two-wire bus joining the controller end and the target end
// open-drain lines pulled high; a driver pulls low only with its enable set
`timescale 1ns/1ps
interface i2cu_if;
   logic scl_o;
   logic scl_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic scl;
   logic sda;

   // wired-and with pull-ups
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

   modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
   modport host (input scl, input sda, output scl_o, output scl_oe,
                 output sda_h_o, output sda_h_oe);
endinterface

// >>> hdl/i2cu_target.sv
// i2c target end of the update port: bit engine clocked by scl, user side on mclk
// assumes scl and sda resolved by i2cu_if and the strap pin tied to gnd, vdd, sda or scl
// Behaviour
// - seven-bit addresses only, ten-bit never matched
// - general call 0x00 then 0x06 resets
// - that reset fires at ack rising edge
// - ninth clock acknowledges, low for whole high
// - sda falling with scl high starts
// - stop releases bus, await start and address
// - sda changes only while scl low
// - acknowledge address only on a match
// - direction bit zero writes, one reads
// - frame is address, command, upper, lower
// - update at falling edge ending lower ack
// - address 1001 plus strap-decoded three bits
// - strap sampled during first byte, latched
// - broadcast 1000111 write matches regardless of strap
// - update only after both data bytes
// - standard, fast and fast-plus rates accepted
// - controller limits update rate
// - nine-bit units repeat until stop
// - controller makes all clocks and conditions
// - read returns upper then lower byte
// - broadcast never serves reads
`timescale 1ns/1ps
`include "i2cu_params.svh"
module i2cu_target
   import i2cu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   i2cu_if.dev              bus,
   input  wire logic        address_strap_pin,
   input  wire logic [15:0] rd_word,
   output logic             frame_act,
   output logic             upd_stb,
   output logic [7:0]       upd_cmd,
   output logic [15:0]      upd_data,
   output logic [7:0]       last_cmd,
   output logic             swrst_stb
);

   // ---------------- mclk side: conditions and user outputs
   logic [1:0]  scl_sync_r;
   logic [1:0]  sda_sync_r;
   logic        scl_q_r;
   logic        sda_q_r;
   logic        frame_clr_r;
   logic        frame_act_r;
   logic [15:0] rd_hold_r;
   logic [2:0]  tgl_s1_r;
   logic [2:0]  tgl_s2_r;
   logic [2:0]  tgl_s3_r;
   logic        upd_stb_r;
   logic [7:0]  upd_cmd_r;
   logic [15:0] upd_data_r;
   logic [7:0]  last_cmd_r;
   logic        swrst_stb_r;

   // ---------------- scl side
   logic [3:0]  bit_cnt_r;
   logic [6:0]  sh_r;
   logic [1:0]  idx_r;
   logic        sel_r;
   logic        rd_r;
   logic        gc_r;
   logic        gc_arm_r;
   logic        eq_sda_r;
   logic        p_one_r;
   logic        n_zero_r;
   logic        ack_due_r;
   logic        tx_act_r;
   logic [15:0] tx_r;
   logic        lo_done_r;
   logic        sda_oe_r;
   logic [7:0]  cmd_r;
   logic [7:0]  up_r;
   logic [7:0]  lo_r;
   logic        upd_tgl_r;
   logic        swrst_tgl_r;
   logic        cmd_tgl_r;

   // conditions seen on synchronised lines; start hold far exceeds sync delay
   wire start_det = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
   wire stop_det  = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];
   wire [2:0] tgl_src = {cmd_tgl_r, swrst_tgl_r, upd_tgl_r};
   wire [2:0] tgl_hit = tgl_s2_r ^ tgl_s3_r;

   // frame clear pulse also resets the scl engine, since scl stands still after stop
   wire lrst_b = rst_b & ~frame_clr_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_q_r    <= 1'b1;
         sda_q_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], bus.scl};
         sda_sync_r <= {sda_sync_r[0], bus.sda};
         scl_q_r    <= scl_sync_r[1];
         sda_q_r    <= sda_sync_r[1];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         frame_clr_r <= 1'b0;
         frame_act_r <= 1'b0;
         rd_hold_r   <= 16'h0000;
      end else begin
         frame_clr_r <= start_det | stop_det;
         if (start_det) begin
            frame_act_r <= 1'b1;
            rd_hold_r   <= rd_word;
         end else if (stop_det) begin
            frame_act_r <= 1'b0;
         end
      end
   end

   // toggle crossings from the scl side; data words stay put for a whole byte
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_s1_r <= 3'h0;
         tgl_s2_r <= 3'h0;
         tgl_s3_r <= 3'h0;
      end else begin
         tgl_s1_r <= tgl_src;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         upd_stb_r   <= 1'b0;
         upd_cmd_r   <= 8'h00;
         upd_data_r  <= 16'h0000;
         last_cmd_r  <= 8'h00;
         swrst_stb_r <= 1'b0;
      end else begin
         upd_stb_r   <= tgl_hit[0];
         swrst_stb_r <= tgl_hit[1];
         if (tgl_hit[0]) begin
            upd_cmd_r  <= cmd_r;
            upd_data_r <= {up_r, lo_r};
         end
         if (tgl_hit[2]) begin
            last_cmd_r <= cmd_r;
         end
      end
   end

   assign frame_act = frame_act_r;
   assign upd_stb   = upd_stb_r;
   assign upd_cmd   = upd_cmd_r;
   assign upd_data  = upd_data_r;
   assign last_cmd  = last_cmd_r;
   assign swrst_stb = swrst_stb_r;

   // ---------------- scl domain decode
   wire       ack_bit    = (bit_cnt_r == `I2CU_ACK_BIT);
   wire       byte_end   = (bit_cnt_r == `I2CU_LAST_DATA_BIT);
   wire       in_addr    = (idx_r == `I2CU_IDX_ADDR);
   wire [7:0] rx_byte    = {sh_r, bus.sda};
   wire       eq_sda_nxt = eq_sda_r & (address_strap_pin == bus.sda);
   wire       p_one_nxt  = p_one_r & address_strap_pin;
   // strap follows sda, or is high at every rise (vdd or scl), else ground
   wire [2:0] strap_code = eq_sda_nxt ? `I2CU_STRAP_SDA :
                           p_one_nxt  ? (n_zero_r ? `I2CU_STRAP_SCL : `I2CU_STRAP_VDD) :
                                        `I2CU_STRAP_GND;
   // ten-bit prefixes never equal these patterns
   wire       own_hit    = (rx_byte[7:1] == {`I2CU_ADDR_HI, strap_code});
   wire       bc_hit     = (rx_byte == {`I2CU_BCAST_ADDR, `I2CU_RW_WRITE});
   wire       gc_hit     = (rx_byte == `I2CU_GCALL_BYTE);
   wire       addr_ok    = own_hit | bc_hit | gc_hit;
   wire       wr_ok      = sel_r & ~rd_r & ~gc_r;
   wire [1:0] idx_nxt    = (idx_r == `I2CU_IDX_LOWER) ? `I2CU_IDX_UPPER : idx_r + 2'h1;

   // rising edge: sample sda; scl is made only by the controller
   always_ff @(posedge bus.scl or negedge lrst_b) begin
      if (!lrst_b) begin
         bit_cnt_r  <= 4'h0;
         sh_r       <= 7'h00;
         idx_r      <= `I2CU_IDX_ADDR;
         sel_r      <= 1'b0;
         rd_r       <= 1'b0;
         gc_r       <= 1'b0;
         gc_arm_r   <= 1'b0;
         eq_sda_r   <= 1'b1;
         p_one_r    <= 1'b1;
         ack_due_r  <= 1'b0;
         tx_act_r   <= 1'b0;
         tx_r       <= 16'hFFFF;
         lo_done_r  <= 1'b0;
      end else begin
         bit_cnt_r <= ack_bit ? 4'h0 : bit_cnt_r + 4'h1;
         lo_done_r <= ack_bit & wr_ok & (idx_r == `I2CU_IDX_LOWER);
         if (!ack_bit) begin
            sh_r <= rx_byte[6:0];
         end
         if (in_addr && !ack_bit) begin
            eq_sda_r <= eq_sda_nxt;
            p_one_r  <= p_one_nxt;
         end
         if (byte_end && in_addr) begin
            sel_r      <= addr_ok;
            rd_r       <= own_hit & (rx_byte[0] == `I2CU_RW_READ);
            gc_r       <= gc_hit;
         end
         gc_arm_r  <= byte_end & gc_r & (idx_r == `I2CU_IDX_CMD) &
                      (rx_byte == `I2CU_GCALL_RESET);
         ack_due_r <= byte_end & (in_addr ? addr_ok : (sel_r & ~rd_r));
         if (ack_bit) begin
            idx_r <= idx_nxt;
         end
         // read transmit: load after address ack, stop on controller nack
         if (ack_bit && in_addr && rd_r) begin
            tx_act_r <= 1'b1;
            tx_r     <= rd_hold_r;
         end else if (ack_bit && tx_act_r && bus.sda) begin
            tx_act_r <= 1'b0;
         end else if (!ack_bit && tx_act_r) begin
            tx_r <= {tx_r[14:0], 1'b1};
         end
      end
   end

   // toggles must survive the frame clear, so they sit on the power-on reset
   always_ff @(posedge bus.scl or negedge rst_b) begin
      if (!rst_b) begin
         swrst_tgl_r <= 1'b0;
         cmd_tgl_r   <= 1'b0;
         cmd_r       <= 8'h00;
         up_r        <= 8'h00;
         lo_r        <= 8'h00;
      end else begin
         if (ack_bit && gc_arm_r) begin
            swrst_tgl_r <= ~swrst_tgl_r;
         end
         if (ack_bit && wr_ok && (idx_r == `I2CU_IDX_CMD)) begin
            cmd_tgl_r <= ~cmd_tgl_r;
         end
         if (byte_end && wr_ok) begin
            if (idx_r == `I2CU_IDX_CMD) begin
               cmd_r <= rx_byte;
            end else if (idx_r == `I2CU_IDX_UPPER) begin
               up_r <= rx_byte;
            end else if (idx_r == `I2CU_IDX_LOWER) begin
               lo_r <= rx_byte;
            end
         end
      end
   end

   // falling edge: drive sda only while scl is low
   wire oe_nxt = ack_due_r | (tx_act_r & ~ack_bit & ~tx_r[15]) |
                 (tx_act_r & (bit_cnt_r == 4'h0) & ~tx_r[15]);

   always_ff @(negedge bus.scl or negedge lrst_b) begin
      if (!lrst_b) begin
         sda_oe_r <= 1'b0;
         n_zero_r <= 1'b1;
      end else begin
         sda_oe_r <= oe_nxt & sel_r | ack_due_r;
         if (in_addr && !ack_bit) begin
            n_zero_r <= n_zero_r & ~address_strap_pin;
         end
      end
   end

   always_ff @(negedge bus.scl or negedge rst_b) begin
      if (!rst_b) begin
         upd_tgl_r <= 1'b0;
      end else if (lo_done_r) begin
         upd_tgl_r <= ~upd_tgl_r;
      end
   end

   // open drain: only the enable moves
   assign bus.sda_d_o  = 1'b0;
   assign bus.sda_d_oe = sda_oe_r;

endmodule

// >>> hdl/i2cu_ctrl.sv
// i2c controller end: makes scl by dividing mclk and runs write, short and read frames
// assumes a target on i2cu_if; sda read back through a two-stage synchroniser
`timescale 1ns/1ps
`include "i2cu_params.svh"
module i2cu_ctrl
   import i2cu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   i2cu_if.host             bus,
   input  wire logic        go,
   input  wire i2cu_op_t    op,
   input  wire logic [6:0]  addr,
   input  wire logic [7:0]  cmd,
   input  wire logic [15:0] wdata,
   output logic             busy,
   output logic             done,
   output logic             nack,
   output logic [15:0]      rdata
);

   localparam int unsigned QCYC = `I2CU_QUARTER_CYC;

   i2cu_hstate_t st_r;
   i2cu_hstate_t st_nxt;
   i2cu_op_t     op_r;
   logic [6:0]   addr_r;
   logic [7:0]   cmd_r;
   logic [15:0]  wdata_r;
   logic [15:0]  rdata_r;
   logic [15:0]  q_cnt_r;
   logic [1:0]   ph_r;
   logic [3:0]   bit_r;
   logic [2:0]   step_r;
   logic [1:0]   sda_sync_r;
   logic         scl_low_r;
   logic         sda_low_r;
   logic         busy_r;
   logic         done_r;
   logic         nack_r;

   wire tick    = (q_cnt_r == 16'(QCYC - 1));
   wire ack_bit = (bit_r == `I2CU_ACK_BIT);
   wire sda_in  = sda_sync_r[1];
   wire is_read = (op_r == I2CU_OP_READ);
   // steps 3 and 4 of a read receive; the address byte after restart is step 2
   wire rx_step = is_read & (step_r >= `I2CU_STEP_RD_UP);
   wire [2:0] last_step = is_read ? `I2CU_STEP_RD_LO :
                          (op_r == I2CU_OP_SHORT) ? `I2CU_STEP_CMD : 3'h3;
   wire [7:0] tx_byte = (step_r == 3'h0) ? {addr_r, `I2CU_RW_WRITE} :
                        (step_r == 3'h1) ? cmd_r :
                        (is_read)        ? {addr_r, `I2CU_RW_READ} :
                        (step_r == 3'h2) ? wdata_r[15:8] : wdata_r[7:0];
   // level to put on sda in this bit: released is one
   wire bit_val = ack_bit ? (rx_step ? (step_r == `I2CU_STEP_RD_LO) : 1'b1) :
                  (rx_step ? 1'b1 : tx_byte[3'(4'h7 - bit_r)]);
   wire end_byte = (st_r == I2CU_H_BIT) & tick & (ph_r == 2'h3) & ack_bit;
   wire got_nack = (st_r == I2CU_H_BIT) & tick & (ph_r == 2'h2) & ack_bit &
                   ~rx_step & sda_in;

   always_comb begin
      st_nxt = st_r;
      if (st_r == I2CU_H_IDLE) begin
         if (go) begin
            st_nxt = I2CU_H_START;
         end
      end else if (tick && (ph_r == 2'h3)) begin
         case (st_r)
            I2CU_H_START: st_nxt = I2CU_H_BIT;
            I2CU_H_BIT: begin
               if (ack_bit) begin
                  if (nack_r || (step_r == last_step)) begin
                     st_nxt = I2CU_H_STOP;
                  end else if (is_read && (step_r == `I2CU_STEP_CMD)) begin
                     st_nxt = I2CU_H_START;
                  end
               end
            end
            default: st_nxt = I2CU_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sda_sync_r <= 2'h3;
      end else begin
         sda_sync_r <= {sda_sync_r[0], bus.sda};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r    <= I2CU_H_IDLE;
         q_cnt_r <= 16'h0000;
         ph_r    <= 2'h0;
      end else begin
         st_r    <= st_nxt;
         q_cnt_r <= ((st_r == I2CU_H_IDLE) || tick) ? 16'h0000 : q_cnt_r + 16'h0001;
         ph_r    <= (st_r == I2CU_H_IDLE) ? 2'h0 : (tick ? ph_r + 2'h1 : ph_r);
      end
   end

   // line drive per quarter: set sda with scl low, raise scl, sample, lower scl
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
      end else if (tick) begin
         case (st_r)
            I2CU_H_START: begin
               scl_low_r <= (ph_r == 2'h3) ? 1'b1 : ((ph_r == 2'h0) & scl_low_r);
               sda_low_r <= (ph_r >= 2'h1) & (ph_r != 2'h1);
            end
            I2CU_H_BIT: begin
               scl_low_r <= (ph_r == 2'h3) | (ph_r == 2'h0);
               sda_low_r <= (ph_r == 2'h0) ? ~bit_val : sda_low_r;
            end
            I2CU_H_STOP: begin
               scl_low_r <= (ph_r == 2'h0);
               sda_low_r <= (ph_r <= 2'h1);
            end
            default: begin
               scl_low_r <= 1'b0;
               sda_low_r <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         op_r    <= I2CU_OP_WRITE;
         addr_r  <= 7'h00;
         cmd_r   <= 8'h00;
         wdata_r <= 16'h0000;
         rdata_r <= 16'h0000;
         bit_r   <= 4'h0;
         step_r  <= 3'h0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
         nack_r  <= 1'b0;
      end else begin
         done_r <= (st_r == I2CU_H_STOP) & tick & (ph_r == 2'h3);
         if ((st_r == I2CU_H_IDLE) && go) begin
            op_r    <= op;
            addr_r  <= addr;
            cmd_r   <= cmd;
            wdata_r <= wdata;
            step_r  <= 3'h0;
            nack_r  <= 1'b0;
            busy_r  <= 1'b1;
         end else if (st_nxt == I2CU_H_IDLE) begin
            busy_r <= 1'b0;
         end
         if (got_nack) begin
            nack_r <= 1'b1;
         end
         if ((st_r == I2CU_H_BIT) && tick && (ph_r == 2'h2) && !ack_bit && rx_step) begin
            rdata_r <= {rdata_r[14:0], sda_in};
         end
         if ((st_r == I2CU_H_START) || (st_r == I2CU_H_IDLE)) begin
            bit_r <= 4'h0;
         end else if ((st_r == I2CU_H_BIT) && tick && (ph_r == 2'h3)) begin
            bit_r <= ack_bit ? 4'h0 : bit_r + 4'h1;
         end
         if (end_byte) begin
            step_r <= step_r + 3'h1;
         end
      end
   end

   assign bus.scl_o    = 1'b0;
   assign bus.scl_oe   = scl_low_r;
   assign bus.sda_h_o  = 1'b0;
   assign bus.sda_h_oe = sda_low_r;
   assign busy  = busy_r;
   assign done  = done_r;
   assign nack  = nack_r;
   assign rdata = rdata_r;

endmodule

// >>> sim/i2cu_chk.sv
// checker on the two-wire bus of the update port
// assumes mclk oversamples scl and the strap stays at STRAP_CODE for the run
`timescale 1ns/1ps
`include "i2cu_params.svh"
module i2cu_chk #(
   parameter logic [2:0] STRAP_CODE = 3'h0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_oe,
   input wire logic sda_d_oe
);
   logic       scl_q_r;
   logic       sda_q_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic       miss_r;
   wire        rise  = scl & ~scl_q_r;
   wire        start = scl & scl_q_r & sda_q_r & ~sda;
   wire        stop  = scl & scl_q_r & ~sda_q_r & sda;
   wire        own   = sh_r[7:1] == {`I2CU_ADDR_HI, STRAP_CODE};
   wire        bcw   = sh_r == {`I2CU_BCAST_ADDR, `I2CU_RW_WRITE};
   wire        known = own | bcw | (sh_r == `I2CU_GCALL_BYTE);
   wire        ninth = rise & (cnt_r == 4'h8);

   // count saturates at 9: only the address byte matters here
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         miss_r  <= 1'b0;
      end else begin
         scl_q_r <= scl;
         sda_q_r <= sda;
         cnt_r   <= start ? 4'h0 : ((rise && cnt_r < 4'h9) ? cnt_r + 4'h1 : cnt_r);
         sh_r    <= rise ? {sh_r[6:0], sda} : sh_r;
         miss_r  <= start ? 1'b0 : (miss_r | (ninth & ~known));
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_scl_host_only: assert property (!scl |-> scl_oe)
      else $error("scl low without controller drive");
   a_ack_holds_high: assert property (scl && scl_q_r |-> $stable(sda_d_oe))
      else $error("target sda drive moved during scl high");
   a_oe_moves_low: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("target sda drive changed with scl high");
   a_ack_on_ninth: assert property (rise && sda_d_oe && cnt_r < 4'h9 |-> cnt_r == 4'h8)
      else $error("address byte acknowledged off the ninth clock");
   a_ack_known_addr: assert property (ninth && sda_d_oe |-> known)
      else $error("foreign address acknowledged");
   a_match_acks: assert property (ninth && own |-> sda_d_oe)
      else $error("own address not acknowledged");
   a_stop_release: assert property (stop |-> ##1 !sda_d_oe [*8])
      else $error("target drives sda after stop");
   a_nomatch_silent: assert property (miss_r |-> !sda_d_oe)
      else $error("unaddressed target drives sda");
endmodule

// >>> sim/tb.sv
// bench joining controller and target ends over the two-wire interface
// assumes scl from the controller divider; strap tied to ground
`timescale 1ns/1ps
`include "i2cu_params.svh"
module tb
   import i2cu_pkg::*;
;
   typedef struct packed {
      logic [1:0]  kind;
      logic        chk_rd;
      logic [23:0] val;
   } i2cu_exp_t;

   logic        mclk;
   logic        rst_b;
   logic        go;
   i2cu_op_t    op;
   logic [6:0]  addr;
   logic [7:0]  cmd;
   logic [15:0] wdata;
   logic [15:0] rd_word;
   logic        busy, done, nack, upd_stb, swrst_stb, frame_act;
   logic [15:0] rdata, upd_data;
   logic [7:0]  upd_cmd, last_cmd;
   int          err_total = 0;
   int          n_checks = 0;
   int          cycles = 0;
   i2cu_exp_t   expq[$];

   i2cu_if i2cu_if_i ();
   i2cu_ctrl i2cu_ctrl_i (.mclk(mclk), .rst_b(rst_b), .bus(i2cu_if_i), .go(go), .op(op),
      .addr(addr), .cmd(cmd), .wdata(wdata), .busy(busy), .done(done), .nack(nack),
      .rdata(rdata));
   i2cu_target i2cu_target_i (.mclk(mclk), .rst_b(rst_b), .bus(i2cu_if_i),
      .address_strap_pin(1'b0), .rd_word(rd_word), .frame_act(frame_act),
      .upd_stb(upd_stb), .upd_cmd(upd_cmd), .upd_data(upd_data), .last_cmd(last_cmd),
      .swrst_stb(swrst_stb));
   i2cu_chk #(.STRAP_CODE(`I2CU_STRAP_GND)) i2cu_chk_i (.mclk(mclk), .rst_b(rst_b),
      .scl(i2cu_if_i.scl), .sda(i2cu_if_i.sda), .scl_oe(i2cu_if_i.scl_oe),
      .sda_d_oe(i2cu_if_i.sda_d_oe));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic note(string what, logic [23:0] exp, logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s exp %h got %h", what, exp, got);
      end
   endtask

   // an empty queue yields kind 3, so a stray result always mismatches
   task automatic take(logic [1:0] k, output i2cu_exp_t e);
      e = (expq.size() == 0) ? {2'h3, 1'b0, 24'h0} : expq.pop_front();
      note("result kind", {22'h0, e.kind}, {22'h0, k});
   endtask

   task automatic chk_upd(logic [23:0] got);
      i2cu_exp_t e;
      take(2'h0, e);
      note("update", e.val, got);
   endtask

   task automatic chk_done(logic n, logic [15:0] rd);
      i2cu_exp_t e;
      take(2'h1, e);
      note("nack", {23'h0, e.val[16]}, {23'h0, n});
      if (e.chk_rd) note("read word", {8'h00, e.val[15:0]}, {8'h00, rd});
   endtask

   task automatic chk_rst;
      i2cu_exp_t e;
      take(2'h2, e);
   endtask

   always @(negedge mclk) begin
      if (upd_stb === 1'b1) chk_upd({upd_cmd, upd_data});
      if (done === 1'b1) chk_done(nack, rdata);
      if (swrst_stb === 1'b1) chk_rst();
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 100000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic push(logic [1:0] k, logic r, logic [23:0] v);
      expq.push_back({k, r, v});
   endtask

   task automatic run(string nm, i2cu_op_t o, logic [6:0] a, logic [7:0] c);
      int i;
      @(negedge mclk);
      go = 1'b1;
      op = o;
      addr = a;
      cmd = c;
      @(negedge mclk);
      go = 1'b0;
      for (i = 0; i < 30000 && done !== 1'b1; i++) @(negedge mclk);
      note({nm, " done"}, 24'h1, {23'h0, done === 1'b1});
      note({nm, " frame active"}, 24'h0, {23'h0, frame_act});
      @(negedge mclk);
      $display("test %s finished", nm);
   endtask

   initial begin
      logic [7:0] c;
      logic [6:0] me;
      go = 1'b0;
      op = I2CU_OP_WRITE;
      addr = 7'h00;
      cmd = 8'h00;
      wdata = 16'h0000;
      rd_word = 16'h0000;
      rst_b = 1'b0;
      me = {`I2CU_ADDR_HI, `I2CU_STRAP_GND};
      void'($urandom(89823));
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      c = 8'($urandom);
      wdata = 16'($urandom);
      push(2'h0, 1'b0, {c, wdata});
      push(2'h1, 1'b0, 24'h0);
      run("write", I2CU_OP_WRITE, me, c);
      note("last command", {16'h0000, c}, {16'h0000, last_cmd});
      push(2'h1, 1'b0, 24'h0);
      run("short", I2CU_OP_SHORT, me, 8'($urandom));
      push(2'h1, 1'b0, 24'h0);
      run("broadcast", I2CU_OP_SHORT, `I2CU_BCAST_ADDR, 8'($urandom));
      push(2'h1, 1'b0, 24'h010000);
      run("ten bit", I2CU_OP_SHORT, 7'h78, 8'($urandom));
      rd_word = 16'($urandom);
      push(2'h1, 1'b1, {8'h00, rd_word});
      run("read", I2CU_OP_READ, me, 8'($urandom));
      push(2'h2, 1'b0, 24'h0);
      push(2'h1, 1'b0, 24'h0);
      run("general call", I2CU_OP_SHORT, 7'h00, `I2CU_GCALL_RESET);
      note("leftover results", 24'h0, 24'(expq.size()));
      report_and_stop();
   end
endmodule
